// File: logic/drp_pkg.sv
// shared constants of the dual rank highway port
package drp_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int DW    = 16;
  localparam int AW    = 5;
  localparam int IRQ_W = 3;
  localparam int CTL_W = 17;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [AW-1:0] REG_CTRL     = 5'h00;
  localparam logic [AW-1:0] REG_IRQ_STAT = 5'h04;
  localparam logic [AW-1:0] REG_IRQ_EN   = 5'h08;
  localparam logic [AW-1:0] REG_IRQ_CLR  = 5'h0c;
  localparam logic [AW-1:0] REG_RX_WORD  = 5'h10;
  localparam logic [AW-1:0] REG_TX_WORD  = 5'h14;
  localparam logic [AW-1:0] REG_PIN_STAT = 5'h18;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int IRQ_RX   = 0;
  localparam int IRQ_TX   = 1;
  localparam int IRQ_PAR  = 2;
  localparam int CTRL_RXG = 0;
  // positions inside the synchronised pin vector
  localparam int P_SEL    = 0;
  localparam int P_LAT_LO = 1;
  localparam int P_LAT_HI = 2;
  localparam int P_LD_LO  = 3;
  localparam int P_LD_HI  = 4;
  localparam int P_RD_LO  = 5;
  localparam int P_RD_HI  = 6;
  localparam int P_ENC    = 7;
  localparam int P_RXSTB  = 8;
  localparam int P_PEN    = 9;
  localparam int P_RXL    = 10;
  localparam int P_ADDR   = 11;
  localparam int P_PAR    = 16;

  // ----------------------------------------
  // values after reset
  // ----------------------------------------
  localparam logic [CTL_W-1:0] SYNC_RST = 17'h002f9;
  localparam logic [DW-1:0]    WORD_RST = 16'h0000;
  localparam logic [IRQ_W-1:0] IRQ_RST  = 3'h0;
  localparam logic             CTRL_RST = 1'h1;
endpackage

// File: logic/drp_rank_if.sv
// signals shared between the port top and its rank modules
`timescale 1ns/1ns
interface drp_rank_if;
  logic [drp_pkg::DW-1:0] hw_data;
  logic                   lat_lo;
  logic                   lat_hi;
  logic                   load_lo;
  logic                   load_hi;
  logic [drp_pkg::DW-1:0] tx_rank1;
  logic [drp_pkg::DW-1:0] tx_rank2;
  logic                   shift_n;
  logic                   bit_in;
  logic                   bit_vld;
  logic [drp_pkg::DW-1:0] rx_rank1;
  logic [drp_pkg::DW-1:0] rx_rank2;
  logic                   rx_done;

  modport top (output hw_data, lat_lo, lat_hi, load_lo, load_hi, shift_n, bit_in, bit_vld,
               input tx_rank1, tx_rank2, rx_rank1, rx_rank2, rx_done);
  modport tx  (input hw_data, lat_lo, lat_hi, load_lo, load_hi, output tx_rank1, tx_rank2);
  modport rx  (input shift_n, bit_in, bit_vld, output rx_rank1, rx_rank2, rx_done);
endinterface

// File: logic/drp_tx_rank.sv
// two rank transmit register, loaded a byte at a time
`timescale 1ns/1ns
module drp_tx_rank (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // rank signals
  drp_rank_if.tx   rk
);
  logic [drp_pkg::DW-1:0] rank1_ff;
  logic [drp_pkg::DW-1:0] rank2_ff;

  // first rank follows the highway while its latch is open
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rank1_ff <= drp_pkg::WORD_RST;
    end else begin
      if (rk.lat_lo) rank1_ff[7:0] <= rk.hw_data[7:0];
      if (rk.lat_hi) rank1_ff[15:8] <= rk.hw_data[15:8];
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rank2_ff <= drp_pkg::WORD_RST;
    end else begin
      if (rk.load_lo) rank2_ff[7:0] <= rank1_ff[7:0];
      if (rk.load_hi) rank2_ff[15:8] <= rank1_ff[15:8];
    end
  end

  assign rk.tx_rank1 = rank1_ff;
  assign rk.tx_rank2 = rank2_ff;
endmodule

// File: logic/drp_rx_rank.sv
// two rank receive register fed by the decoder bit stream
`timescale 1ns/1ns
module drp_rx_rank (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // rank signals
  drp_rank_if.rx   rk
);
  logic [drp_pkg::DW-1:0] rank1_ff;
  logic [drp_pkg::DW-1:0] rank2_ff;
  logic                   shift_n_ff;
  logic                   done_ff;
  logic                   xfer;

  assign xfer = rk.shift_n && !shift_n_ff;

  // bits enter msb first while shifting is indicated
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rank1_ff <= drp_pkg::WORD_RST;
    end else if (!rk.shift_n && rk.bit_vld) begin
      rank1_ff <= {rank1_ff[14:0], rk.bit_in};
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      shift_n_ff <= 1'b1;
    end else begin
      shift_n_ff <= rk.shift_n;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rank2_ff <= drp_pkg::WORD_RST;
      done_ff  <= 1'b0;
    end else begin
      if (xfer) rank2_ff <= rank1_ff;
      done_ff <= xfer;
    end
  end

  assign rk.rx_rank1 = rank1_ff;
  assign rk.rx_rank2 = rank2_ff;
  assign rk.rx_done  = done_ff;
endmodule

// File: logic/drp_port.sv
// subsystem highway port: dual rank registers, strobes, parity flag
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module drp_port (
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  // register port
  input  wire logic [drp_pkg::AW-1:0]  reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [31:0]             reg_rdata,
  output logic                         irq,
  // subsystem strobes
  input  wire logic                    port_select_n,
  input  wire logic                    tx_latch_lo,
  input  wire logic                    tx_latch_hi,
  input  wire logic                    tx_load_lo_n,
  input  wire logic                    tx_load_hi_n,
  input  wire logic                    rd_lo_n,
  input  wire logic                    rd_hi_n,
  input  wire logic                    encoder_go_n,
  input  wire logic                    rx_strobe_n,
  input  wire logic                    addr_parity_check_en_n,
  input  wire logic [4:0]              term_addr,
  input  wire logic                    term_addr_par,
  // data highway
  input  wire logic [drp_pkg::DW-1:0]  hw_in,
  output logic      [drp_pkg::DW-1:0]  hw_out,
  output logic      [drp_pkg::DW-1:0]  hw_oe_n,
  // receiver and decoder side
  input  wire logic                    rx_line_in,
  input  wire logic                    rx_shift_n,
  input  wire logic                    rx_bit,
  input  wire logic                    rx_bit_vld,
  output logic                         rx_line_out,
  // encoder side
  output logic                         encoder_start_n,
  output logic      [drp_pkg::DW-1:0]  tx_word,
  output logic                         odd_parity
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [drp_pkg::CTL_W-1:0] ctl_s1_ff;
  logic [drp_pkg::CTL_W-1:0] ctl_s2_ff;
  logic [drp_pkg::DW-1:0]    hw_s1_ff;
  logic [drp_pkg::DW-1:0]    hw_s2_ff;
  logic [drp_pkg::CTL_W-1:0] ctl_raw;
  logic                      sel_n_s;
  logic                      rd_lo_en;
  logic                      rd_hi_en;
  logic                      ld_lo_s;
  logic                      ld_hi_s;
  logic                      ld_any_ff;
  logic                      par_en_n_s;
  logic                      par_odd;
  logic                      par_flag;
  logic                      ctrl_rxg_ff;
  logic [drp_pkg::IRQ_W-1:0] irq_stat_ff;
  logic [drp_pkg::IRQ_W-1:0] irq_en_ff;
  logic [drp_pkg::IRQ_W-1:0] irq_evt;
  logic [drp_pkg::IRQ_W-1:0] irq_clr;
  logic [31:0]               nxt_rdata;
  logic                      rx_line_out_ff;
  logic                      enc_start_n_ff;
  logic                      odd_parity_ff;
  logic [drp_pkg::DW-1:0]    hw_out_ff;
  logic [drp_pkg::DW-1:0]    hw_oe_n_ff;
  logic [drp_pkg::DW-1:0]    tx_word_ff;
  logic [31:0]               rdata_ff;
  logic                      irq_ff;

  drp_rank_if rk ();

  // a read select only counts while the port is selected
  function automatic logic lane_en(input logic strobe_n, input logic sel_n);
    return !strobe_n && !sel_n;
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  assign ctl_raw = {term_addr_par, term_addr, rx_line_in, addr_parity_check_en_n,
                    rx_strobe_n, encoder_go_n, rd_hi_n, rd_lo_n, tx_load_hi_n,
                    tx_load_lo_n, tx_latch_hi, tx_latch_lo, port_select_n};

  // idle levels at reset keep the highway released and loads locked
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctl_s1_ff <= drp_pkg::SYNC_RST;
      ctl_s2_ff <= drp_pkg::SYNC_RST;
    end else begin
      ctl_s1_ff <= ctl_raw;
      ctl_s2_ff <= ctl_s1_ff;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      hw_s1_ff <= drp_pkg::WORD_RST;
      hw_s2_ff <= drp_pkg::WORD_RST;
    end else begin
      hw_s1_ff <= hw_in;
      hw_s2_ff <= hw_s1_ff;
    end
  end

  assign sel_n_s    = ctl_s2_ff[drp_pkg::P_SEL];
  assign rd_lo_en   = lane_en(ctl_s2_ff[drp_pkg::P_RD_LO], sel_n_s);
  assign rd_hi_en   = lane_en(ctl_s2_ff[drp_pkg::P_RD_HI], sel_n_s);
  assign ld_lo_s    = !ctl_s2_ff[drp_pkg::P_LD_LO];
  assign ld_hi_s    = !ctl_s2_ff[drp_pkg::P_LD_HI];
  assign par_en_n_s = ctl_s2_ff[drp_pkg::P_PEN];

  // ----------------------------------------
  // rank modules
  // ----------------------------------------
  assign rk.hw_data = hw_s2_ff;
  assign rk.lat_lo  = ctl_s2_ff[drp_pkg::P_LAT_LO] && !sel_n_s;
  assign rk.lat_hi  = ctl_s2_ff[drp_pkg::P_LAT_HI] && !sel_n_s;
  assign rk.load_lo = ld_lo_s;
  assign rk.load_hi = ld_hi_s;
  assign rk.shift_n = rx_shift_n;
  assign rk.bit_in  = rx_bit;
  assign rk.bit_vld = rx_bit_vld;

  drp_tx_rank u_tx (
    .ref_clk (ref_clk),
    .reset   (reset),
    .rk      (rk.tx)
  );

  drp_rx_rank u_rx (
    .ref_clk (ref_clk),
    .reset   (reset),
    .rk      (rk.rx)
  );

  // ----------------------------------------
  // data highway drive
  // ----------------------------------------
  // lanes not selected float so the subsystem can write
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      hw_out_ff  <= drp_pkg::WORD_RST;
      hw_oe_n_ff <= ~drp_pkg::WORD_RST;
    end else begin
      hw_out_ff[7:0]   <= rd_lo_en ? rk.rx_rank2[7:0] : 8'h00;
      hw_oe_n_ff[7:0]  <= {8{!rd_lo_en}};
      hw_out_ff[15:8]  <= rd_hi_en ? rk.rx_rank2[15:8] : 8'h00;
      hw_oe_n_ff[15:8] <= {8{!rd_hi_en}};
    end
  end

  // ----------------------------------------
  // receiver gate, encoder start, parity
  // ----------------------------------------
  assign par_odd  = ^{ctl_s2_ff[drp_pkg::P_PAR], ctl_s2_ff[drp_pkg::P_ADDR +: 5]};
  assign par_flag = par_odd && !par_en_n_s;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rx_line_out_ff <= 1'b0;
    end else begin
      rx_line_out_ff <= ctl_s2_ff[drp_pkg::P_RXL] && ctl_s2_ff[drp_pkg::P_RXSTB]
                        && ctrl_rxg_ff;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      enc_start_n_ff <= 1'b1;
    end else begin
      enc_start_n_ff <= !lane_en(ctl_s2_ff[drp_pkg::P_ENC], sel_n_s);
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      odd_parity_ff <= 1'b0;
    end else begin
      odd_parity_ff <= par_flag;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tx_word_ff <= drp_pkg::WORD_RST;
    end else begin
      tx_word_ff <= rk.tx_rank2;
    end
  end

  // ----------------------------------------
  // interrupt status
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ld_any_ff <= 1'b0;
    end else begin
      ld_any_ff <= ld_lo_s || ld_hi_s;
    end
  end

  assign irq_evt[drp_pkg::IRQ_RX]  = rk.rx_done;
  assign irq_evt[drp_pkg::IRQ_TX]  = (ld_lo_s || ld_hi_s) && !ld_any_ff;
  assign irq_evt[drp_pkg::IRQ_PAR] = par_flag && !odd_parity_ff;
  assign irq_clr = (reg_wr && reg_addr == drp_pkg::REG_IRQ_CLR) ?
                   reg_wdata[drp_pkg::IRQ_W-1:0] : drp_pkg::IRQ_RST;

  // a new event outranks a clear in the same cycle
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq_stat_ff <= drp_pkg::IRQ_RST;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_evt;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(((irq_stat_ff & ~irq_clr) | irq_evt) & irq_en_ff);
    end
  end

  // ----------------------------------------
  // register port
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_rxg_ff <= drp_pkg::CTRL_RST;
      irq_en_ff   <= drp_pkg::IRQ_RST;
    end else if (reg_wr) begin
      if (reg_addr == drp_pkg::REG_CTRL) ctrl_rxg_ff <= reg_wdata[drp_pkg::CTRL_RXG];
      if (reg_addr == drp_pkg::REG_IRQ_EN) irq_en_ff <= reg_wdata[drp_pkg::IRQ_W-1:0];
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (reg_addr)
      drp_pkg::REG_CTRL:     nxt_rdata[drp_pkg::CTRL_RXG] = ctrl_rxg_ff;
      drp_pkg::REG_IRQ_STAT: nxt_rdata[drp_pkg::IRQ_W-1:0] = irq_stat_ff;
      drp_pkg::REG_IRQ_EN:   nxt_rdata[drp_pkg::IRQ_W-1:0] = irq_en_ff;
      drp_pkg::REG_RX_WORD:  nxt_rdata[drp_pkg::DW-1:0] = rk.rx_rank2;
      drp_pkg::REG_TX_WORD:  nxt_rdata[drp_pkg::DW-1:0] = rk.tx_rank2;
      drp_pkg::REG_PIN_STAT: nxt_rdata[drp_pkg::CTL_W-1:0] = ctl_s2_ff;
      default:               nxt_rdata = 32'h0000_0000;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= reg_rd ? nxt_rdata : 32'h0000_0000;
    end
  end

  assign reg_rdata       = rdata_ff;
  assign irq             = irq_ff;
  assign hw_out          = hw_out_ff;
  assign hw_oe_n         = hw_oe_n_ff;
  assign rx_line_out     = rx_line_out_ff;
  assign encoder_start_n = enc_start_n_ff;
  assign tx_word         = tx_word_ff;
  assign odd_parity      = odd_parity_ff;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  sequence s_shift_end;
    !rx_shift_n ##1 rx_shift_n;
  endsequence

  sequence s_lo_load;
    ld_lo_s ##1 1'b1;
  endsequence

  // tx_word trails the second rank by one cycle, so a quiet load shows two edges later
  sequence s_hi_locked;
    !ld_hi_s ##2 1'b1;
  endsequence

  AST_LOAD_LO: assert property (s_lo_load |-> ##1 tx_word[7:0] == $past(rk.tx_rank1[7:0], 2))
    else $error("low byte not loaded from first rank");

  AST_LOAD_HI: assert property (s_hi_locked |-> tx_word[15:8] == $past(tx_word[15:8]))
    else $error("high byte of second rank moved while locked");

  AST_READ_LO: assert property (rd_lo_en |=> hw_oe_n[7:0] == 8'h00
                                && hw_out[7:0] == $past(rk.rx_rank2[7:0]))
    else $error("low lanes not driven with receive word");

  AST_READ_HI: assert property (rd_hi_en |=> hw_oe_n[15:8] == 8'h00
                                && hw_out[15:8] == $past(rk.rx_rank2[15:8]))
    else $error("high lanes not driven with receive word");

  AST_FLOAT: assert property (!rd_lo_en && !rd_hi_en |=> hw_oe_n == 16'hffff)
    else $error("highway driven without a read select");

  AST_LO_FLOAT: assert property (!rd_lo_en |=> hw_oe_n[7:0] == 8'hff && hw_out[7:0] == 8'h00)
    else $error("low lanes driven without low read select");

  AST_RX_GATE: assert property (!ctl_s2_ff[drp_pkg::P_RXSTB] |=> !rx_line_out)
    else $error("receiver output passed while strobe low");

  AST_PAR_OFF: assert property (par_en_n_s |=> !odd_parity)
    else $error("parity flag high while check disabled");

  AST_PAR_ON: assert property (!par_en_n_s && par_odd |=> odd_parity)
    else $error("odd parity not flagged");

  AST_DESELECT: assert property (sel_n_s |=> encoder_start_n && $stable(rk.tx_rank1))
    else $error("strobe honoured while port deselected");

  AST_LATCH_LO: assert property (rk.lat_lo |=> rk.tx_rank1[7:0] == $past(hw_s2_ff[7:0]))
    else $error("first rank low byte did not follow highway");

  AST_RX_XFER: assert property (s_shift_end |=> rk.rx_rank2 == $past(rk.rx_rank1)
                                && rk.rx_done)
    else $error("receive word not transferred on shift end");
endmodule

// File: tb/drp_subsys_model.sv
// subsystem side of the highway: drives transmit data while the port lets go
`timescale 1ns/1ns
module drp_subsys_model (
  // clock
  input  wire logic                   ref_clk,
  // port side of the highway
  input  wire logic [drp_pkg::DW-1:0] hw_out,
  input  wire logic [drp_pkg::DW-1:0] hw_oe_n,
  output logic      [drp_pkg::DW-1:0] hw_in,
  // bench control
  input  wire logic [drp_pkg::DW-1:0] drv_data,
  input  wire logic                   drv_en,
  output logic                        clash
);
  // --------
  // lane resolution
  // --------
  logic [drp_pkg::DW-1:0] float_ff = 16'ha5a5;

  // no pull on the lanes: an idle lane must never look like held data
  always @(posedge ref_clk) begin
    float_ff <= ~float_ff;
  end

  assign hw_in = (~hw_oe_n & hw_out) | (hw_oe_n & (drv_en ? drv_data : float_ff));
  assign clash = drv_en & (hw_oe_n != 16'hffff);
endmodule

// File: tb/tb_dual_rank_io_registers.sv
// self-checking bench for the dual rank highway port
`timescale 1ns/1ns
module tb_dual_rank_io_registers;
  // --------
  // signals
  // --------
  logic                   ref_clk;
  logic                   reset;
  logic [drp_pkg::AW-1:0] reg_addr;
  logic [31:0]            reg_wdata, reg_rdata, tmp;
  logic                   reg_wr, reg_rd, irq, b, vld;
  logic                   port_select_n, tx_latch_lo, tx_latch_hi, tx_load_lo_n, tx_load_hi_n;
  logic                   rd_lo_n, rd_hi_n, encoder_go_n, rx_strobe_n, addr_parity_check_en_n;
  logic [4:0]             term_addr;
  logic                   term_addr_par, rx_line_in, rx_shift_n, rx_bit, rx_bit_vld;
  logic [drp_pkg::DW-1:0] hw_in, hw_out, hw_oe_n, tx_word, drv_data, exp_oe, v1, v2;
  logic                   rx_line_out, encoder_start_n, odd_parity, drv_en, clash;
  int                     mismatches, compares, seed, n, rx_model, tx_model;

  drp_port dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .port_select_n(port_select_n), .tx_latch_lo(tx_latch_lo), .tx_latch_hi(tx_latch_hi),
    .tx_load_lo_n(tx_load_lo_n), .tx_load_hi_n(tx_load_hi_n), .rd_lo_n(rd_lo_n), .rd_hi_n(rd_hi_n),
    .encoder_go_n(encoder_go_n), .rx_strobe_n(rx_strobe_n),
    .addr_parity_check_en_n(addr_parity_check_en_n), .term_addr(term_addr),
    .term_addr_par(term_addr_par), .hw_in(hw_in), .hw_out(hw_out), .hw_oe_n(hw_oe_n),
    .rx_line_in(rx_line_in), .rx_shift_n(rx_shift_n), .rx_bit(rx_bit), .rx_bit_vld(rx_bit_vld),
    .rx_line_out(rx_line_out), .encoder_start_n(encoder_start_n), .tx_word(tx_word),
    .odd_parity(odd_parity));

  drp_subsys_model sub (.ref_clk(ref_clk), .hw_out(hw_out), .hw_oe_n(hw_oe_n), .hw_in(hw_in),
    .drv_data(drv_data), .drv_en(drv_en), .clash(clash));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // --------
  // tasks
  // --------
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // lets the edge land, then samples settled outputs
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  task automatic reg_write(input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic chk_reg(input logic [4:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk_val(reg_rdata, exp, "register read");
  endtask

  task automatic end_sim;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    if (clash === 1'b1) begin
      mismatches++;
      $display("MISMATCH t=%0t highway driven from both sides", $time);
    end
  end

  initial begin
    repeat (100000) @(posedge ref_clk);
    mismatches++;
    $display("MISMATCH t=%0t run did not finish", $time);
    end_sim();
  end

  // --------
  // main sequence
  // --------
  initial begin
    seed = 32'h54a3;
    mismatches = 0;
    compares = 0;
    reset = 1'b1;
    {reg_addr, reg_wdata, reg_wr, reg_rd, tx_latch_lo, tx_latch_hi, rx_bit, rx_bit_vld} = '0;
    {port_select_n, tx_load_lo_n, tx_load_hi_n, rd_lo_n, rd_hi_n, encoder_go_n} = 6'h3f;
    {rx_strobe_n, addr_parity_check_en_n, rx_shift_n} = 3'h7;
    {term_addr, term_addr_par, rx_line_in, drv_en, drv_data} = '0;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    chk_val(32'(hw_oe_n), 32'hffff, "lanes after reset");
    chk_reg(drp_pkg::REG_CTRL, 32'h1);
    chk_reg(drp_pkg::REG_IRQ_STAT, 32'h0);
    chk_reg(drp_pkg::REG_IRQ_EN, 32'h0);
    chk_reg(drp_pkg::REG_TX_WORD, 32'h0);
    chk_reg(5'h1c, 32'h0);
    // receive word, valid bits thinned at random
    rx_model = 0;
    n = 0;
    @(posedge ref_clk);
    rx_shift_n <= 1'b0;
    for (int k = 0; k < 64 && n < 16; k++) begin
      tmp = $random(seed);
      b = tmp[0];
      vld = tmp[1] | tmp[2];
      rx_bit <= b;
      rx_bit_vld <= vld;
      @(posedge ref_clk);
      if (vld) begin
        rx_model = ((rx_model << 1) | int'(b)) & 32'hffff;
        n++;
      end
    end
    if (n < 16) begin
      mismatches++;
      $display("MISMATCH t=%0t bit stream not finished", $time);
      end_sim();
    end
    rx_shift_n <= 1'b1;
    rx_bit_vld <= 1'b0;
    cyc(4);
    chk_reg(drp_pkg::REG_RX_WORD, rx_model);
    reg_write(drp_pkg::REG_RX_WORD, 32'hffff);
    chk_reg(drp_pkg::REG_RX_WORD, rx_model);
    chk_reg(drp_pkg::REG_IRQ_STAT, 32'h1);
    chk_val(32'(irq), 32'h0, "irq masked");
    reg_write(drp_pkg::REG_IRQ_EN, 32'h1);
    cyc(2);
    chk_val(32'(irq), 32'h1, "irq raised");
    reg_write(drp_pkg::REG_IRQ_CLR, 32'h1);
    cyc(2);
    chk_val(32'(irq), 32'h0, "irq cleared");
    chk_reg(drp_pkg::REG_IRQ_STAT, 32'h0);
    // every select combination, with and without port select
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      port_select_n <= i[2];
      rd_lo_n <= i[0];
      rd_hi_n <= i[1];
      cyc(6);
      exp_oe = {{8{i[1] | i[2]}}, {8{i[0] | i[2]}}};
      chk_val(32'(hw_oe_n), 32'(exp_oe), "lane enables");
      chk_val(32'(hw_out), 32'(~exp_oe & rx_model[15:0]), "lane data");
    end
    // transmit: latch, close, load, a byte at a time
    tmp = $random(seed);
    v1 = tmp[15:0];
    v2 = ~tmp[31:16];
    @(posedge ref_clk);
    drv_data <= v1;
    drv_en <= 1'b1;
    port_select_n <= 1'b0;
    tx_latch_lo <= 1'b1;
    cyc(6);
    tx_latch_lo <= 1'b0;
    cyc(6);
    tx_load_lo_n <= 1'b0;
    cyc(6);
    tx_model = {24'h0, v1[7:0]};
    chk_val(32'(tx_word), tx_model, "low byte load");
    tx_load_lo_n <= 1'b1;
    drv_data <= v2;
    tx_latch_hi <= 1'b1;
    cyc(6);
    chk_val(32'(tx_word), tx_model, "second rank locked");
    tx_latch_hi <= 1'b0;
    cyc(6);
    tx_load_lo_n <= 1'b0;
    tx_load_hi_n <= 1'b0;
    cyc(6);
    tx_model = {16'h0, v2[15:8], v1[7:0]};
    chk_val(32'(tx_word), tx_model, "high byte load");
    port_select_n <= 1'b1;
    drv_data <= ~v2;
    tx_latch_lo <= 1'b1;
    tx_latch_hi <= 1'b1;
    cyc(6);
    chk_val(32'(tx_word), tx_model, "latch while deselected");
    {tx_latch_lo, tx_latch_hi, tx_load_lo_n, tx_load_hi_n, drv_en} <= 5'h6;
    cyc(6);
    chk_reg(drp_pkg::REG_TX_WORD, tx_model);
    chk_reg(drp_pkg::REG_IRQ_STAT, 32'h2);
    // receiver gate: line, strobe, control bit
    for (int i = 0; i < 8; i++) begin
      reg_write(drp_pkg::REG_CTRL, 32'(i[2]));
      rx_line_in <= i[0];
      rx_strobe_n <= i[1];
      cyc(6);
      chk_val(32'(rx_line_out), 32'(i[0] & i[1] & i[2]), "receiver gate");
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      port_select_n <= i[0];
      encoder_go_n <= i[1];
      cyc(6);
      chk_val(32'(encoder_start_n), 32'(i[0] | i[1]), "encoder start");
    end
    for (int i = 0; i < 12; i++) begin
      tmp = $random(seed);
      @(posedge ref_clk);
      term_addr <= tmp[4:0];
      term_addr_par <= tmp[5];
      addr_parity_check_en_n <= tmp[6];
      cyc(6);
      chk_val(32'(odd_parity), 32'(~tmp[6] & ^tmp[5:0]), "odd parity");
    end
    chk_reg(drp_pkg::REG_PIN_STAT, 32'({tmp[5:0], 1'b1, tmp[6], 1'b1, 8'hf9}));
    end_sim();
  end
endmodule
